// ==== tm1_control.sv ====
// Timer control register and count-enable generation for a 16-bit timer.
// Assumes a register master on clk, a counter that advances on count_tick,
// and gate and external clock pins that are asynchronous to clk.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns

module tm1_control (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Register port
  input  wire logic [tm1_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [tm1_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [tm1_pkg::DATA_W-1:0]  reg_rdata,
  // Device state
  input  wire logic                        idle_mode,
  // Pins
  input  wire logic                        gate_in,
  input  wire logic                        external_count_input,
  // Towards the counter
  output logic                             count_tick,
  output logic                             run_enable,
  output logic                             stop_in_idle,
  output logic                             gate_accumulate_enable,
  output logic      [1:0]                  prescale_select,
  output logic                             ext_clock_sync_select,
  output logic                             clock_source_select
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [tm1_pkg::DATA_W-1:0] ctrl_reg;       // timer_one_control
  logic [tm1_pkg::DATA_W-1:0] ctrl_next;
  logic [tm1_pkg::DATA_W-1:0] rdata_reg;      // Read data, one cycle late
  logic [tm1_pkg::DATA_W-1:0] rdata_next;
  logic                       hit;            // Address selects the register

  logic gate_meta_reg;                        // Gate synchroniser, first stage
  logic gate_sync_reg;                        // Gate synchroniser, second stage
  logic ext_meta_reg;                         // External clock, first stage
  logic ext_sync_reg;                         // External clock, second stage
  logic ext_prev_reg;                         // Previous synchronised level
  logic gate_meta_next;
  logic gate_sync_next;
  logic ext_meta_next;
  logic ext_sync_next;
  logic ext_prev_next;

  logic phase_reg;                            // Instruction clock phase
  logic phase_next;
  logic instr_en;                             // One pulse per instruction cycle

  logic pend_reg;                             // External edge awaiting alignment
  logic pend_next;
  logic ext_rise;                             // Rising edge of external clock
  logic src_pulse;                            // One edge of the chosen source
  logic run_ok;                               // Timer allowed to advance
  logic ps_tick;                              // Prescaler output

  logic tick_reg;                             // Registered count enable
  logic tick_next;

  // ==========================================================
  // Field views
  // ==========================================================
  // All come straight from flip-flops, the fields from the control flip-flops
  assign run_enable             = ctrl_reg[tm1_pkg::RUN_BIT];
  assign stop_in_idle           = ctrl_reg[tm1_pkg::IDLE_BIT];
  assign gate_accumulate_enable = ctrl_reg[tm1_pkg::GATE_BIT];
  assign prescale_select        = ctrl_reg[tm1_pkg::PS_HI:tm1_pkg::PS_LO];
  assign ext_clock_sync_select  = ctrl_reg[tm1_pkg::SYNC_BIT];
  assign clock_source_select    = ctrl_reg[tm1_pkg::SRC_BIT];
  assign reg_rdata              = rdata_reg;
  assign count_tick             = tick_reg;

  // ==========================================================
  // Register port
  // ==========================================================
  assign hit = (reg_addr == tm1_pkg::CTRL_OFFSET);

  // Write masks off the unimplemented positions
  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_write && hit) begin
      ctrl_next = reg_wdata & tm1_pkg::CTRL_IMPL;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_next = tm1_pkg::READ_IDLE;
    if (reg_read && hit) begin
      rdata_next = ctrl_reg & tm1_pkg::CTRL_IMPL;
    end
  end

  // Register state; control clears fully so the timer starts stopped
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg  <= tm1_pkg::CTRL_RESET;
      rdata_reg <= tm1_pkg::READ_IDLE;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Both pins cross two flops; logic never reads the first stage
  always_comb begin
    gate_meta_next = gate_in;
    gate_sync_next = gate_meta_reg;
    ext_meta_next  = external_count_input;
    ext_sync_next  = ext_meta_reg;
    ext_prev_next  = ext_sync_reg;
  end

  // Register
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
      ext_meta_reg  <= 1'b0;
      ext_sync_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
    end else begin
      gate_meta_reg <= gate_meta_next;
      gate_sync_reg <= gate_sync_next;
      ext_meta_reg  <= ext_meta_next;
      ext_sync_reg  <= ext_sync_next;
      ext_prev_reg  <= ext_prev_next;
    end
  end

  // Rising edge seen after synchronisation
  assign ext_rise = ext_sync_reg && !ext_prev_reg;

  // ==========================================================
  // Instruction clock divider
  // ==========================================================
  // Internal source runs at half the oscillator rate
  always_comb begin
    if (phase_reg == tm1_pkg::INSTR_LAST_PHASE) begin
      phase_next = 1'b0;
    end else begin
      phase_next = 1'b1;
    end
  end

  assign instr_en = (phase_reg == tm1_pkg::INSTR_LAST_PHASE);

  // Register
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================
  // Source selection, gating and alignment
  // ==========================================================
  // Halt in Idle only when asked; otherwise Idle does not matter
  assign run_ok = run_enable && !(idle_mode && stop_in_idle);

  // Pick one edge of the chosen source per step
  always_comb begin
    src_pulse = 1'b0;
    pend_next = 1'b0;
    if (clock_source_select) begin
      // External source: gate bit plays no part here
      if (ext_clock_sync_select) begin
        // Hold the edge until the next instruction cycle boundary
        src_pulse = instr_en && (pend_reg || ext_rise);
        pend_next = !instr_en && (pend_reg || ext_rise);
      end else begin
        // Unaligned: counted on the edge as soon as it is seen
        src_pulse = ext_rise;
      end
    end else begin
      // Internal source, optionally gated by the pin level
      if (gate_accumulate_enable) begin
        src_pulse = instr_en && gate_sync_reg;
      end else begin
        src_pulse = instr_en;
      end
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ==========================================================
  // Prescaler
  // ==========================================================
  // Cleared while stopped so each start begins a full period
  tm1_prescaler u_prescaler (
    .clk    (clk),
    .reset  (reset),
    .clear  (!run_enable),
    .step   (src_pulse && run_ok),
    .select (prescale_select),
    .tick   (ps_tick)
  );

  // ==========================================================
  // Count enable output
  // ==========================================================
  // Registered so the counter sees a clean flop-driven pulse;
  // costs one cycle of latency against the source edge
  always_comb begin
    tick_next = ps_tick;
  end

  // Register
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
    end
  end

endmodule

// ==== tm1_pkg.sv ====
// Constants for the timer control block: register map, field layout,
// prescale codes and the instruction clock divider.
// Assumes a single 100 MHz clock that stands for the oscillator.
package tm1_pkg;

  // ==========================================================
  // Bus geometry
  // ==========================================================
  localparam int unsigned ADDR_W = 4;               // Register port address width
  localparam int unsigned DATA_W = 16;              // Register width

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;      // timer_one_control
  localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;  // All bits clear at reset
  localparam logic [DATA_W-1:0] CTRL_IMPL   = 16'ha076;  // Implemented bit positions
  localparam logic [DATA_W-1:0] READ_IDLE   = 16'h0000;  // Read data outside a read

  // ==========================================================
  // Field positions in timer_one_control
  // ==========================================================
  localparam int unsigned RUN_BIT  = 15;            // run_enable
  localparam int unsigned IDLE_BIT = 13;            // stop_in_idle
  localparam int unsigned GATE_BIT = 6;             // gate_accumulate_enable
  localparam int unsigned PS_HI    = 5;             // prescale_select, upper bit
  localparam int unsigned PS_LO    = 4;             // prescale_select, lower bit
  localparam int unsigned SYNC_BIT = 2;             // ext_clock_sync_select
  localparam int unsigned SRC_BIT  = 1;             // clock_source_select

  // ==========================================================
  // Prescale codes and terminal counts
  // ==========================================================
  localparam int unsigned PS_CNT_W = 8;             // Enough for divide by 256
  localparam logic [1:0] PS_DIV1   = 2'h0;          // 1:1
  localparam logic [1:0] PS_DIV8   = 2'h1;          // 1:8
  localparam logic [1:0] PS_DIV64  = 2'h2;          // 1:64
  localparam logic [1:0] PS_DIV256 = 2'h3;          // 1:256
  localparam logic [PS_CNT_W-1:0] PS_LAST1   = 8'h00;
  localparam logic [PS_CNT_W-1:0] PS_LAST8   = 8'h07;
  localparam logic [PS_CNT_W-1:0] PS_LAST64  = 8'h3f;
  localparam logic [PS_CNT_W-1:0] PS_LAST256 = 8'hff;
  localparam logic [PS_CNT_W-1:0] PS_STEP    = 8'h01;

  // ==========================================================
  // Instruction clock: oscillator divided by two
  // ==========================================================
  localparam int unsigned CLK_HZ    = 100_000_000;  // clk rate, stands for the oscillator
  localparam int unsigned INSTR_DIV = 2;            // Instruction clock = clk / 2
  localparam logic INSTR_LAST_PHASE = 1'(INSTR_DIV - 1);

endpackage

// ==== tm1_prescaler.sv ====
// Prescaler for the timer: passes one tick out of 1, 8, 64 or 256 steps.
// Assumes step is a one-cycle pulse on clk; clear restarts the count.
`timescale 1ns/1ns

module tm1_prescaler (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       clear,      // Restart division from zero
  input  wire logic       step,       // One source edge
  input  wire logic [1:0] select,     // prescale_select code
  // Result
  output logic            tick        // One pulse per divided period
);

  // ==========================================================
  // Division counter
  // ==========================================================
  logic [tm1_pkg::PS_CNT_W-1:0] cnt_reg;   // Steps seen in this period
  logic [tm1_pkg::PS_CNT_W-1:0] cnt_next;
  logic [tm1_pkg::PS_CNT_W-1:0] last;      // Terminal count for the code

  // Terminal count from the code
  always_comb begin
    case (select)
      tm1_pkg::PS_DIV1:   last = tm1_pkg::PS_LAST1;
      tm1_pkg::PS_DIV8:   last = tm1_pkg::PS_LAST8;
      tm1_pkg::PS_DIV64:  last = tm1_pkg::PS_LAST64;
      tm1_pkg::PS_DIV256: last = tm1_pkg::PS_LAST256;
      default:            last = tm1_pkg::PS_LAST1;
    endcase
  end

  // Tick on the step that completes a period
  assign tick = step && (cnt_reg >= last);

  // Next count; a shrunk code mid-period wraps on the next step via >=
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = '0;
    end else if (step) begin
      cnt_next = cnt_reg + tm1_pkg::PS_STEP;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ==== tm1_control_sva.sv ====
// Checker for the timer control block: register port and count path.
// Assumes it is bound to tm1_control and sees only that module's ports.
`timescale 1ns/1ns

module tm1_control_sva (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Register port
  input wire logic [tm1_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tm1_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [tm1_pkg::DATA_W-1:0] reg_rdata,
  // Device state and pins
  input wire logic                       idle_mode,
  input wire logic                       gate_in,
  input wire logic                       external_count_input,
  // Towards the counter
  input wire logic                       count_tick,
  input wire logic                       run_enable,
  input wire logic                       stop_in_idle,
  input wire logic                       gate_accumulate_enable,
  input wire logic [1:0]                 prescale_select,
  input wire logic                       ext_clock_sync_select,
  input wire logic                       clock_source_select
);
  // ==========================================================
  // Helpers
  // ==========================================================
  logic [15:0] fields;  // Control word rebuilt from the field ports
  logic        steady;  // Internal source, divide by one, nothing halting
  assign fields = {run_enable, 1'b0, stop_in_idle, 6'h00, gate_accumulate_enable, prescale_select,
                   1'b0, ext_clock_sync_select, clock_source_select, 1'b0};
  assign steady = run_enable && !clock_source_select && !gate_accumulate_enable &&
                  prescale_select == 2'h0 && !(idle_mode && stop_in_idle);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Register port
  // ==========================================================
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_read_fields: assert property ($past(reg_read) && $past(reg_addr) == 4'h0
    |-> reg_rdata == $past(fields))
    else $error("read data differs from control fields");
  a_read_unmapped: assert property ($past(reg_read) && $past(reg_addr) != 4'h0
    |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_write_fields: assert property (reg_write && reg_addr == 4'h0
    |=> fields == ($past(reg_wdata) & 16'ha076))
    else $error("write did not land in implemented bits");
  a_fields_hold: assert property (!(reg_write && reg_addr == 4'h0) |=> $stable(fields))
    else $error("control fields changed without a write");

  // ==========================================================
  // Count path
  // ==========================================================
  a_stop_quiet: assert property (!run_enable && !$past(run_enable) |-> !count_tick)
    else $error("tick while stopped");
  a_idle_halt: assert property (idle_mode && stop_in_idle && $past(idle_mode && stop_in_idle)
    |-> !count_tick)
    else $error("tick during idle halt");
  // Steps come at most every second cycle, so a divided period spans well over six cycles
  a_div_spacing: assert property (count_tick && prescale_select != 2'h0 && !reg_write ##1 !reg_write [*6]
    |-> !count_tick)
    else $error("divided ticks too close");
  a_internal_half: assert property (steady [*4] ##0 $past(count_tick, 2)
    |-> count_tick && !$past(count_tick))
    else $error("internal ticks not every second cycle");
  a_gate_block: assert property ((run_enable && !clock_source_select && gate_accumulate_enable && !gate_in) [*7]
    |-> !count_tick)
    else $error("tick with gate closed");
  a_ext_edge: assert property ((run_enable && clock_source_select && !external_count_input) [*8]
    |-> !count_tick)
    else $error("external tick without an edge");

  // Main scenarios reached
  c_ext_tick: cover property (count_tick && clock_source_select);
  c_gate_tick: cover property (count_tick && gate_accumulate_enable);
  c_read_word: cover property ($past(reg_read) && reg_rdata != 16'h0000);
endmodule

bind tm1_control tm1_control_sva chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .gate_in(gate_in),
  .external_count_input(external_count_input), .count_tick(count_tick), .run_enable(run_enable),
  .stop_in_idle(stop_in_idle), .gate_accumulate_enable(gate_accumulate_enable),
  .prescale_select(prescale_select), .ext_clock_sync_select(ext_clock_sync_select),
  .clock_source_select(clock_source_select));

// ==== tm1_control_tb_top.sv ====
// Self-checking bench for the timer control block.
// Assumes tm1_control as top, one 100 MHz clock and the bound checker.
`timescale 1ns/1ns

module tm1_control_tb_top;
  // ==========================================================
  // Signals
  // ==========================================================
  logic                        clk, reset, reg_write, reg_read;
  logic [tm1_pkg::ADDR_W-1:0]  reg_addr;
  logic [tm1_pkg::DATA_W-1:0]  reg_wdata, reg_rdata;
  logic                        idle_mode, gate_in, external_count_input, count_tick;
  logic                        run_enable, stop_in_idle, gate_accumulate_enable;
  logic                        ext_clock_sync_select, clock_source_select;
  logic [1:0]                  prescale_select;
  int                          n_mismatch, samples_checked, seed;
  logic [15:0]                 d, e;  // Random word and its expected readback
  logic [3:0]                  a;     // Target address, unmapped on every fourth word
  logic [15:0]                 ext_modes [4] = '{16'h8002, 16'h8042, 16'h8046, 16'h8006};

  tm1_control dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .gate_in(gate_in),
    .external_count_input(external_count_input), .count_tick(count_tick), .run_enable(run_enable),
    .stop_in_idle(stop_in_idle), .gate_accumulate_enable(gate_accumulate_enable),
    .prescale_select(prescale_select), .ext_clock_sync_select(ext_clock_sync_select),
    .clock_source_select(clock_source_select));

  // Free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  // Only the documented positions survive a write
  function automatic logic [15:0] exp_ctrl(input logic [15:0] w);
    return w & 16'ha076;
  endfunction

  // Division ratio of each prescale code
  function automatic int ps_div(input int code);
    return (code == 0) ? 1 : (code == 1) ? 8 : (code == 2) ? 64 : 256;
  endfunction

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // One-cycle read strobe, data looked at in the following cycle only
  task automatic rd(input logic [3:0] ad, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    check16(reg_rdata, exp, "read data");
  endtask

  task automatic chk_fields(input logic [15:0] exp);
    check16({run_enable, 1'b0, stop_in_idle, 6'h00, gate_accumulate_enable, prescale_select, 1'b0,
             ext_clock_sync_select, clock_source_select, 1'b0}, exp, "field ports");
  endtask

  // Counts ticks; with tog the external pin rises every 8 cycles, then drains
  task automatic meas(input int cyc, input bit tog, input int lo, input int hi);
    int t;
    t = 0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < cyc + (tog ? 8 : 0); i++) begin
      @(posedge clk);
      if (tog && i < cyc && i % 4 == 0) external_count_input <= ~external_count_input;
      @(negedge clk);
      if (count_tick === 1'b1) t++;
    end
    samples_checked++;
    if (t < lo || t > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: %0d ticks, want %0d to %0d", $time, t, lo, hi);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 12k cycles
  initial begin
    #500000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 11;
    reset = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {idle_mode, gate_in, external_count_input} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, 16'h0000);
    chk_fields(16'h0000);
    // Random words, some aimed at unmapped addresses
    e = 16'h0000;
    for (int i = 0; i < 24; i++) begin
      d = 16'($random(seed));
      a = 4'((i % 4 == 3) ? (i / 4) + 1 : 0);
      wr(a, d);
      if (a == 4'h0) e = exp_ctrl(d);
      rd(4'h0, e);
      rd(a, (a == 4'h0) ? e : 16'h0000);
      chk_fields(e);
    end
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'ha076);
    // Every prescale code on the internal clock: sixteen divided periods each
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, 16'h0000);
      wr(4'h0, {8'h80, 2'b00, 2'(c), 4'h0});
      meas(2 * ps_div(c) * 16, 1'b0, 15, 17);
    end
    wr(4'h0, 16'h0000);
    meas(100, 1'b0, 0, 0);
    @(posedge clk) idle_mode <= 1'b1;
    wr(4'h0, 16'ha000);
    meas(100, 1'b0, 0, 0);
    wr(4'h0, 16'h8000);
    meas(100, 1'b0, 49, 51);
    @(posedge clk) idle_mode <= 1'b0;
    wr(4'h0, 16'h8004);
    meas(100, 1'b0, 49, 51);
    @(posedge clk) gate_in <= 1'b0;
    wr(4'h0, 16'h8040);
    meas(100, 1'b0, 0, 0);
    @(posedge clk) gate_in <= 1'b1;
    meas(100, 1'b0, 49, 51);
    // External source, gate bit and sync bit in every mix
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) gate_in <= 1'($random(seed));
      wr(4'h0, ext_modes[m]);
      meas(80, 1'b1, 10, 10);
    end
    wr(4'h0, 16'h0000);
    end_sim();
  end
endmodule
